// [verilog/fple_entry.sv]
// Exception entry sequencer with lazy FP stacking and load replay
`include "fple_defines.svh"

module fple_entry
    import fple_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Register port
    input  wire logic [31:0]   i_addr,
    input  wire logic [31:0]   i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic [31:0]        o_rdata,
    // Exception sequencing
    input  wire logic          i_exc_take,
    input  wire logic          i_fp_ctx_active,
    input  wire logic          i_stack_done,
    output logic               o_fp_push,
    input  wire logic          i_fp_push_done,
    output logic               o_handler_go,
    input  wire logic          i_handler_fp_instr,
    output logic               o_fp_stall,
    input  wire logic          i_exc_return,
    output logic               o_return_go,
    // Divide / square root
    input  wire logic          i_div_issue,
    input  wire logic [4:0]    i_div_dest,
    input  wire logic [31:0]   i_div_result,
    input  wire logic [4:0]    i_div_flags,
    output logic               o_div_busy,
    output fple_wb_t           o_wb,
    // Stack-pointer load tracking
    input  wire logic          i_sp_load_issue,
    input  wire logic [31:0]   i_sp_load_addr,
    input  wire logic          i_sp_load_wb,
    input  wire logic          i_sp_load_data_ok,
    output fple_replay_t       o_replay
);

    // ****************************************************************
    // State
    // ****************************************************************
    fple_state_t state;
    logic [3:0]  ent_cnt;
    logic        lazy_en;
    logic        lazy_pending;
    logic        div_done;
    logic [4:0]  div_dest;
    logic        ld_out;
    logic [31:0] ld_addr;
    logic        ld_base_upd;
    logic        restart_pend;
    logic        ctrl_hit;
    logic        take;

    assign ctrl_hit = (i_addr == `FPLE_CTRL_ADDR);
    assign take     = (state == FPLE_IDLE) && i_exc_take;

    // ****************************************************************
    // Divide timer
    // ****************************************************************
    fple_div_timer #(
        .LATENCY (`FPLE_DIV_CYCLES)
    ) u_div (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_issue (i_div_issue),
        .i_dest  (i_div_dest),
        .o_busy  (o_div_busy),
        .o_done  (div_done),
        .o_dest  (div_dest)
    );

    // Writeback port is separate from stacking so it never waits on it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb <= '0;
        end else begin
            o_wb.valid <= div_done;
            if (div_done) begin
                o_wb.dest  <= div_dest;
                o_wb.data  <= i_div_result;
                o_wb.flags <= i_div_flags;
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Only the enable bit is writable; pending bit is read-only status
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lazy_en <= `FPLE_LAZY_EN_RESET;
        end else if (i_wr && ctrl_hit) begin
            lazy_en <= i_wdata[`FPLE_LAZY_EN_BIT];
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd && ctrl_hit) begin
            o_rdata <= (32'(lazy_en) << `FPLE_LAZY_EN_BIT)
                     | (32'(lazy_pending) << `FPLE_LAZY_PEND_BIT);
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Exception sequencer
    // ****************************************************************
    // Nested exceptions are not accepted here; the core holds them off
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state        <= FPLE_IDLE;
            ent_cnt      <= 4'h0;
            o_handler_go <= 1'b0;
            o_return_go  <= 1'b0;
        end else begin
            o_handler_go <= 1'b0;
            o_return_go  <= 1'b0;
            if (state != FPLE_IDLE && ent_cnt != 4'hF) begin
                ent_cnt <= ent_cnt + 4'h1;
            end
            unique case (state)
                FPLE_IDLE: begin
                    if (i_exc_take) begin
                        state   <= FPLE_ENTRY;
                        ent_cnt <= 4'h1;
                    end
                end
                FPLE_ENTRY: begin
                    // Count holds the cycle number since the take, saturating at 15
                    if (ent_cnt >= 4'(`FPLE_ENTRY_MIN - 1) && i_stack_done
                        && !o_fp_push) begin
                        o_handler_go <= 1'b1;
                        state        <= FPLE_HANDLER;
                    end
                end
                FPLE_HANDLER: begin
                    if (i_exc_return && !o_fp_push) begin
                        state <= FPLE_DRAIN;
                    end
                end
                FPLE_DRAIN: begin
                    // Unstacking waits for a pending divide so it lands
                    if (!o_div_busy && !div_done) begin
                        o_return_go <= 1'b1;
                        state       <= FPLE_IDLE;
                    end
                end
                // Unused codes of the state word fall back to idle
                default: begin
                    state <= FPLE_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // FP context push, eager or lazy
    // ****************************************************************
    // Lazy mode only marks the context; the push is paid on first use
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lazy_pending <= 1'b0;
            o_fp_push    <= 1'b0;
            o_fp_stall   <= 1'b0;
        end else begin
            if (take && i_fp_ctx_active) begin
                if (lazy_en) begin
                    lazy_pending <= 1'b1;
                end else begin
                    o_fp_push    <= 1'b1;
                    lazy_pending <= 1'b0; // A stale mark must not survive an eager entry
                end
            end else if (state == FPLE_HANDLER && lazy_pending
                         && i_handler_fp_instr && !o_fp_push) begin
                o_fp_push  <= 1'b1;
                o_fp_stall <= 1'b1;
            end else if (o_fp_push && i_fp_push_done) begin
                o_fp_push    <= 1'b0;
                o_fp_stall   <= 1'b0;
                lazy_pending <= 1'b0;
            end else if (o_return_go) begin
                lazy_pending <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Stack-pointer load replay
    // ****************************************************************
    // Base register was already written at issue, so replay skips it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ld_out       <= 1'b0;
            ld_addr      <= 32'h0000_0000;
            ld_base_upd  <= 1'b0;
            restart_pend <= 1'b0;
            o_replay     <= '0;
        end else begin
            o_replay.valid <= 1'b0;
            if (i_sp_load_issue) begin
                ld_out      <= 1'b1;
                ld_addr     <= i_sp_load_addr;
                ld_base_upd <= i_sp_load_wb;
            end else if (i_sp_load_data_ok) begin
                ld_out <= 1'b0;
            end
            if (take && ld_out && !i_sp_load_data_ok) begin
                restart_pend <= 1'b1;
                ld_out       <= 1'b0;
            end
            if (state == FPLE_DRAIN && !o_div_busy && !div_done) begin
                restart_pend      <= 1'b0;
                o_replay.valid    <= restart_pend;
                o_replay.addr     <= restart_pend ? ld_addr : 32'h0000_0000; // Payload only with a replay
                o_replay.base_upd <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_take;
        state == FPLE_IDLE && i_exc_take;
    endsequence

    sequence s_lazy_take;
        s_take ##0 (lazy_en && i_fp_ctx_active);
    endsequence

    AST_LAZY_RESET: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_rst) |-> lazy_en)
        else $error("lazy save not enabled after reset");

    AST_HANDLER_MIN: assert property (@(posedge i_clk) disable iff (i_rst)
        o_handler_go |-> ent_cnt >= 4'(`FPLE_ENTRY_MIN))
        else $error("handler started before 12 cycles");

    AST_LAZY_DEFER: assert property (@(posedge i_clk) disable iff (i_rst)
        s_lazy_take |=> lazy_pending && !o_fp_push)
        else $error("lazy entry pushed FP state");

    AST_EAGER_PUSH: assert property (@(posedge i_clk) disable iff (i_rst)
        s_take ##0 (!lazy_en && i_fp_ctx_active) |=> o_fp_push && !lazy_pending)
        else $error("disabled lazy save did not push at entry");

    AST_LAZY_PUSH: assert property (@(posedge i_clk) disable iff (i_rst)
        state == FPLE_HANDLER && lazy_pending && i_handler_fp_instr && !o_fp_push
        |=> o_fp_push && o_fp_stall)
        else $error("first FP instruction did not trigger push");

    AST_DIV_SURVIVES: assert property (@(posedge i_clk) disable iff (i_rst)
        s_take ##0 o_div_busy |-> ##[1:15] o_wb.valid)
        else $error("divide lost across exception");

    AST_NO_EARLY_RETURN: assert property (@(posedge i_clk) disable iff (i_rst)
        o_return_go |-> !$past(o_div_busy) && !$past(div_done))
        else $error("return while divide in flight");

    AST_REPLAY: assert property (@(posedge i_clk) disable iff (i_rst)
        s_take ##0 (ld_out && !i_sp_load_data_ok) |=> restart_pend)
        else $error("interrupted load not marked for replay");

    AST_BASE_ONCE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_replay.valid |-> o_return_go && !o_replay.base_upd)
        else $error("replay would update base again");

    AST_CSR_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        i_wr && ctrl_hit |=> lazy_en == $past(i_wdata[`FPLE_LAZY_EN_BIT]))
        else $error("enable bit write not taken");

    // A push request stays up until the memory side reports it done
    sequence s_push_open;
        o_fp_push && !i_fp_push_done;
    endsequence

    sequence s_push_close;
        o_fp_push && i_fp_push_done;
    endsequence

    AST_PUSH_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        s_push_open |=> o_fp_push)
        else $error("FP push request dropped before done");

    AST_PUSH_CLOSE: assert property (@(posedge i_clk) disable iff (i_rst)
        s_push_close |=> !o_fp_push && !o_fp_stall && !lazy_pending)
        else $error("FP push not closed after done");

    AST_STALL_ONLY_PUSH: assert property (@(posedge i_clk) disable iff (i_rst)
        o_fp_stall |-> o_fp_push)
        else $error("FP stall without a push in progress");

    AST_GO_AFTER_PUSH: assert property (@(posedge i_clk) disable iff (i_rst)
        o_handler_go |-> !$past(o_fp_push))
        else $error("handler started while FP push open");

    AST_RDATA_STANDS: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(i_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    AST_REPLAY_ADDR: assert property (@(posedge i_clk) disable iff (i_rst)
        o_replay.valid |-> o_replay.addr == $past(ld_addr))
        else $error("replay address is not the interrupted load");

endmodule

// [verilog/fple_defines.svh]
// Constants for the floating-point lazy exception entry block
// What this block does
// - Divide and square root take 14 cycles
// - In-flight divide completes and writes back through exceptions
// - Lazy mode defers FP push to first FP instruction
// - Lazy saving comes up enabled after reset
// - Handler starts no sooner than 12 cycles after entry
// - Bit 30 at 0xE000EF34; zero forces immediate push
// - Interrupted stack-pointer load is executed again on return
`ifndef FPLE_DEFINES_SVH
`define FPLE_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FPLE_CTRL_ADDR      32'hE000_EF34
`define FPLE_LAZY_EN_BIT    30
`define FPLE_LAZY_PEND_BIT  0
`define FPLE_LAZY_EN_RESET  1'b1

// ****************************************************************
// Timing counts, in core clock cycles
// ****************************************************************
`define FPLE_DIV_CYCLES     14
`define FPLE_ENTRY_MIN      12

`endif

// [verilog/fple_pkg.sv]
// Types shared by the lazy exception entry block
package fple_pkg;

    // Divide / square-root writeback to register bank and status reg
    typedef struct packed {
        logic        valid;
        logic [4:0]  dest;
        logic [31:0] data;
        logic [4:0]  flags;
    } fple_wb_t;

    // Replay request for an interrupted stack-pointer load
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        base_upd;
    } fple_replay_t;

    // Exception sequencing states
    typedef enum logic [2:0] {
        FPLE_IDLE,
        FPLE_ENTRY,
        FPLE_HANDLER,
        FPLE_DRAIN
    } fple_state_t;

endpackage

// [verilog/fple_div_timer.sv]
// Fixed-latency tracker for divide and square-root operations
`include "fple_defines.svh"

module fple_div_timer #(
    parameter int LATENCY = `FPLE_DIV_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_issue,
    input  wire logic [4:0] i_dest,
    output logic            o_busy,
    output logic            o_done,
    output logic [4:0]      o_dest
);

    logic [4:0] cnt;

    // Counts from issue; exceptions have no input here, so nothing aborts it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt    <= 5'h0_0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_dest <= 5'h0_0;
        end else begin
            o_done <= 1'b0;
            if (i_issue && !o_busy) begin
                cnt    <= 5'h0_1;
                o_busy <= 1'b1;
                o_dest <= i_dest;
            end else if (o_busy) begin
                if (cnt == 5'(LATENCY - 1)) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
                cnt <= cnt + 5'h0_1;
            end
        end
    end

    AST_DIV_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst)
        i_issue && !o_busy |=> !o_done [*8] ##1 !o_done [*5] ##1 o_done)
        else $error("divide did not complete in 14 cycles");

endmodule

// [tb/fple_stack_model.sv]
// Stack memory model facing the exception entry sequencer
module fple_stack_model (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_slow,
    input  wire logic i_exc_take,
    input  wire logic i_handler_go,
    input  wire logic i_fp_push,
    output logic      o_stack_done,
    output logic      o_fp_push_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] stk_cnt;
    logic [4:0] push_cnt;
    logic [4:0] wait_n;

    // Never zero wait: a prompt memory still adds a wait state
    assign wait_n = i_slow ? 5'h10 : 5'h02;

    // Integer stacking; done stays up until the handler starts
    always_ff @(posedge i_clk) begin
        if (i_rst || i_handler_go) begin
            stk_cnt <= 5'h00;
            o_stack_done <= 1'b0;
        end else if (i_exc_take && stk_cnt == 5'h00 && !o_stack_done) begin
            stk_cnt <= wait_n;
        end else if (stk_cnt == 5'h01) begin
            stk_cnt <= 5'h00;
            o_stack_done <= 1'b1;
        end else if (stk_cnt != 5'h00) begin
            stk_cnt <= stk_cnt - 5'h01;
        end
    end

    // One done pulse per push; the pulse itself blocks a re-trigger
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            push_cnt <= 5'h00;
            o_fp_push_done <= 1'b0;
        end else begin
            o_fp_push_done <= push_cnt == 5'h01;
            if (push_cnt != 5'h00) begin
                push_cnt <= push_cnt - 5'h01;
            end else if (i_fp_push && !o_fp_push_done) begin
                push_cnt <= wait_n;
            end
        end
    end
endmodule

// [tb/test_fple_entry.sv]
// Self-checking bench for the lazy exception entry block
module test_fple_entry;
    timeunit 1ns;
    timeprecision 1ps;
    import fple_pkg::*;
    localparam logic [31:0] CTRL = 32'hE000_EF34;
    logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, slow = 0;
    logic        i_exc_take = 0, i_fp_ctx_active = 0, i_handler_fp_instr = 0;
    logic        i_exc_return = 0, i_div_issue = 0, i_sp_load_issue = 0;
    logic        i_sp_load_wb = 0, i_sp_load_data_ok = 0;
    logic [4:0]  i_div_dest = 5'h0a, i_div_flags = 5'h15;
    logic [31:0] i_addr = 0, i_wdata = 0, i_div_result = 32'h1234_5678;
    logic [31:0] i_sp_load_addr = 0, o_rdata, v, nx;
    logic        i_stack_done, i_fp_push_done, o_fp_push, o_handler_go;
    logic        o_fp_stall, o_return_go, o_div_busy, fpi_q = 0, push_q = 0;
    logic        st_push, push_go;
    fple_wb_t     o_wb, wb_q;
    fple_replay_t o_replay, rep_q;
    int cyc = 0, n_busy = 0, err_total = 0, checks = 0;
    int t_take = -1, t_iss = -1, t_rq = -1, t_done = -1, t_fpi = -1;
    int t_push = -1, t_pdrop = -1, t_go = -1, t_ret = -1, t_wb = -1;
    // Write address, write data, read address, expected read data
    logic [127:0] rows [6] = '{
        {CTRL, 32'h0000_0000, CTRL, 32'h0000_0000},
        {CTRL, 32'hFFFF_FFFF, CTRL, 32'h4000_0000},
        {32'hE000_EF30, 32'h0000_0000, CTRL, 32'h4000_0000},
        {CTRL, 32'hBFFF_FFFF, CTRL, 32'h0000_0000},
        {32'hE000_EF38, 32'hFFFF_FFFF, 32'hE000_EF38, 32'h0000_0000},
        {CTRL, 32'h4000_0000, CTRL, 32'h4000_0000}};

    fple_entry i_fple_entry (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_exc_take, .i_fp_ctx_active, .i_stack_done, .o_fp_push,
        .i_fp_push_done, .o_handler_go, .i_handler_fp_instr, .o_fp_stall,
        .i_exc_return, .o_return_go, .i_div_issue, .i_div_dest, .i_div_result,
        .i_div_flags, .o_div_busy, .o_wb, .i_sp_load_issue, .i_sp_load_addr,
        .i_sp_load_wb, .i_sp_load_data_ok, .o_replay);
    fple_stack_model i_fple_stack_model (.i_clk, .i_rst, .i_slow(slow),
        .i_exc_take, .i_handler_go(o_handler_go), .i_fp_push(o_fp_push),
        .o_stack_done(i_stack_done), .o_fp_push_done(i_fp_push_done));

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    // ****************************************************************
    // Event recorder: the cycle in which each signal was sampled
    // ****************************************************************
    always @(posedge i_clk) begin
        if (i_exc_take) t_take = cyc;
        if (i_div_issue) t_iss = cyc;
        if (i_exc_return) t_rq = cyc;
        if (i_fp_push_done) t_done = cyc;
        if (i_handler_fp_instr && !fpi_q) t_fpi = cyc;
        if (o_fp_push && !push_q) t_push = cyc;
        if (o_fp_push && !push_q) st_push = o_fp_stall;
        if (!o_fp_push && push_q) t_pdrop = cyc;
        if (o_handler_go) t_go = cyc;
        if (o_handler_go) push_go = o_fp_push;
        if (o_return_go) t_ret = cyc;
        if (o_return_go) rep_q = o_replay;
        if (o_wb.valid) t_wb = cyc;
        if (o_wb.valid) wb_q = o_wb;
        if (o_div_busy) n_busy++;
        fpi_q = i_handler_fp_instr;
        push_q = o_fp_push;
        cyc++;
    end

    task automatic chk_val(input string n, input logic [42:0] e, input logic [42:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_cyc(input string n, input int e, input int g);
        checks++;
        if (g != e) begin
            err_total++;
            $display("unexpected %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic wait_for(ref int t);
        int old;
        old = t;
        // Look at negedges so the recorder has run; resume on a rising edge
        for (int k = 0; k < 80 && t == old; k++) @(negedge i_clk);
        @(posedge i_clk);
        if (t == old) chk_cyc("wait", 1, 0);
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 0;
    endtask
    task automatic rd_reg(input logic [31:0] a);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 0;
        @(negedge i_clk) v = o_rdata;
        @(negedge i_clk) nx = o_rdata;
        @(posedge i_clk);
    endtask
    task automatic pulse_return();
        i_exc_return <= 1;
        @(posedge i_clk);
        i_exc_return <= 0;
        i_div_issue <= 0;
        wait_for(t_ret);
    endtask
    // Exception taken one cycle after the divide and load issue
    task automatic take(input logic ctx);
        @(posedge i_clk);
        i_div_issue <= 0;
        i_sp_load_issue <= 0;
        i_exc_take <= 1;
        i_fp_ctx_active <= ctx;
        @(posedge i_clk);
        i_exc_take <= 0;
        wait_for(t_go);
    endtask
    task automatic give_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog far beyond the hundred-odd cycles the tests need
    initial begin
        #20000;
        err_total++;
        give_verdict();
    end

    // ****************************************************************
    // Register rows, then the exception scenarios
    // ****************************************************************
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 0;
        @(posedge i_clk);
        chk_val("idle", 43'h0, 43'({o_fp_push, o_fp_stall, o_div_busy, o_wb.valid}));
        rd_reg(CTRL);
        chk_val("reset ctrl", 43'h4000_0000, 43'(v));
        for (int r = 0; r < 6; r++) begin
            wr_reg(rows[r][127:96], rows[r][95:64]);
            rd_reg(rows[r][63:32]);
            chk_val("ctrl row", 43'(rows[r][31:0]), 43'(v));
            chk_val("rdata stand", 43'h0, 43'(nx));
        end
        // Lazy entry with a divide in flight
        i_div_issue <= 1;
        take(1);
        chk_cyc("entry time", 12, t_go - t_take);
        chk_val("push at go", 43'h0, 43'(push_go));
        rd_reg(CTRL);
        chk_val("pending", 43'h4000_0001, 43'(v));
        i_handler_fp_instr <= 1;
        wait_for(t_pdrop);
        i_handler_fp_instr <= 0;
        chk_cyc("push delay", 1, t_push - t_fpi);
        chk_val("stall", 43'h1, 43'(st_push));
        chk_cyc("push drop", 1, t_pdrop - t_done);
        chk_cyc("div time", 15, t_wb - t_iss);
        // Issue edge plus 13 busy edges make the 14-cycle operation
        chk_cyc("div busy", 13, n_busy);
        chk_val("div wb", {1'b1, 5'h0a, 32'h1234_5678, 5'h15}, wb_q);
        pulse_return();
        chk_cyc("return", 2, t_ret - t_rq);
        // Load to the stack pointer and divide caught mid-flight
        i_div_result <= 32'hCAFE_0001;
        i_div_issue <= 1;
        i_sp_load_issue <= 1;
        i_sp_load_addr <= 32'h2000_1000;
        i_sp_load_wb <= 1;
        take(0);
        // A divide issued with the return must hold back the unstacking
        i_div_issue <= 1;
        pulse_return();
        chk_cyc("held return", 1, int'(t_ret > t_wb && t_wb > t_take));
        chk_val("div wb", {1'b1, 5'h0a, 32'hCAFE_0001, 5'h15}, wb_q);
        chk_val("replay", 43'({1'b1, 32'h2000_1000, 1'b0}), 43'(rep_q));
        // Lazy off, slow memory, completed load gives no replay
        wr_reg(CTRL, 32'h0000_0000);
        slow <= 1;
        i_sp_load_issue <= 1;
        @(posedge i_clk);
        i_sp_load_issue <= 0;
        i_sp_load_data_ok <= 1;
        @(posedge i_clk);
        i_sp_load_data_ok <= 0;
        take(1);
        chk_cyc("eager push", 1, t_push - t_take);
        chk_cyc("go after push", 1, int'(t_go > t_pdrop && t_go - t_take >= 12));
        pulse_return();
        chk_val("no replay", 43'h0, 43'(rep_q));
        // Reset in mid-run brings the lazy enable back on
        i_rst <= 1;
        repeat (2) @(posedge i_clk);
        i_rst <= 0;
        @(posedge i_clk);
        rd_reg(CTRL);
        chk_val("ctrl after reset", 43'h4000_0000, 43'(v));
        give_verdict();
    end
endmodule
